/* rtl/e1c_pkg.sv */
// Constants for the second control page register group, E1 mode
package e1c_pkg;
    // Host port page and register offsets
    localparam logic [2:0] PAGE_CTRL2 = 3'h2;
    localparam logic [4:0] OFS_CFG = 5'h10;
    localparam logic [4:0] OFS_CPE = 5'h11;
    localparam logic [4:0] OFS_PW1 = 5'h1c;
    localparam logic [4:0] OFS_PW2 = 5'h1d;
    localparam logic [4:0] OFS_PW3 = 5'h1e;
    localparam logic [4:0] OFS_PW4 = 5'h1f;
    // Configuration control fields
    localparam int CFG_E1_BIT = 7;
    localparam int CFG_FE_DIS_BIT = 4;
    localparam int CFG_LOS_BIT = 3;
    localparam int CFG_TEST_BIT = 1;
    // Custom pulse enable field
    localparam int CPE_CUSTOM_BIT = 3;
    // Pulse word magnitude width
    localparam int MAG_W = 7;
    // Reset values
    localparam logic [7:0] CFG_RST = 8'h80;
    localparam logic [7:0] CPE_RST = 8'h80;
    localparam logic [6:0] MAG_RST = 7'h00;
    localparam logic [7:0] RD_ZERO = 8'h00;
    // Loss-of-signal thresholds, dB below nominal
    localparam logic [5:0] LOS_LOW_DB = 6'd40;
    localparam logic [5:0] LOS_HIGH_DB = 6'd20;
    // Clock rates and the fractional divider for the 2.048 MHz output
    localparam int SYS_CLK_KHZ = 10000;
    localparam int LINE_CLK_KHZ = 2048;
    localparam int ACC_W = 16;
    localparam logic [ACC_W-1:0] TOGGLE_INC =
        ACC_W'((64'(LINE_CLK_KHZ) * 2 * (64'(1) << ACC_W)) /
        64'(SYS_CLK_KHZ));
endpackage

/* rtl/e1c_regs.sv */
// Second control page register group with line and pulse steering
//
// Notes on behaviour
// - Configuration bit 7 high selects E1 mode
// - Bit 4 high disables front-end, framer only
// - Digital rx lines sampled on ext clock rise
// - Digital tx lines launched on clock output rise
// - Bit 3 picks 40 or 20 dB LOS
// - Bit 1 low: PRBS drives and checks slots
// - Custom bit low: ROM templates per termination
// - Custom bit high: phases use programmed words
// - Word 1 magnitude shapes first phase
// - Word 2 magnitude shapes second phase
// - Custom magnitudes act only with enable set
// - Words 3 and 4 shape phases three, four
`timescale 1ns/1ps
`default_nettype none
module e1c_regs
    import e1c_pkg::*;
(
    // Clock and reset
    input wire logic clk_i,
    input wire logic reset_n_i,
    // Parallel host port
    input wire logic host_cs_i,
    input wire logic host_wr_i,
    input wire logic host_rd_i,
    input wire logic [2:0] host_page_i,
    input wire logic [4:0] host_addr_i,
    input wire logic [7:0] host_wdata_i,
    output logic [7:0] host_rdata_o,
    output logic host_rvalid_o,
    // Mode and line settings
    output logic e1_mode_select_o,
    output logic line_frontend_disable_o,
    output logic los_threshold_select_o,
    output logic [5:0] los_threshold_db_o,
    // Per-timeslot test source steering
    input wire logic tx_slot_test_flag_i,
    input wire logic rx_slot_test_flag_i,
    output logic tx_milliwatt_sel_o,
    output logic tx_prbs_gen_sel_o,
    output logic rx_milliwatt_sel_o,
    output logic rx_prbs_chk_sel_o,
    // Digital framer-only line interface
    input wire logic ext_rx_line_clock_i,
    input wire logic rx_line_in_a_i,
    input wire logic rx_line_in_b_i,
    output logic rx_data_a_o,
    output logic rx_data_b_o,
    output logic rx_data_strobe_o,
    input wire logic tx_data_a_i,
    input wire logic tx_data_b_i,
    output logic tx_line_out_a_o,
    output logic tx_line_out_b_o,
    output logic tx_data_taken_o,
    output logic sys_clock_out_o,
    // Transmit pulse shaping
    input wire logic mark_active_i,
    input wire logic [1:0] mark_phase_i,
    input wire logic [MAG_W-1:0] rom_coeff_i,
    output logic custom_pulse_enable_o,
    output logic [MAG_W-1:0] driver_coeff_o
);

    logic [7:0] cfg_q, cpe_q;
    logic [MAG_W-1:0] mag_q [0:3];
    logic [7:0] rdata_q, rd_mux;
    logic rvalid_q, wr_hit, rd_hit;

    // Page decode is shared by reads and writes
    assign wr_hit = host_cs_i && host_wr_i && (host_page_i == PAGE_CTRL2);
    assign rd_hit = host_cs_i && host_rd_i && (host_page_i == PAGE_CTRL2);

    // Reserved bits are stored as written; software keeps them zero
    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            cfg_q <= CFG_RST;
        end else if (wr_hit && host_addr_i == OFS_CFG) begin
            cfg_q <= host_wdata_i;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            cpe_q <= CPE_RST;
        end else if (wr_hit && host_addr_i == OFS_CPE) begin
            cpe_q <= host_wdata_i;
        end
    end

    // Bit 7 of each pulse word is not kept and reads as zero
    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            mag_q <= '{default: MAG_RST};
        end else if (wr_hit) begin
            case (host_addr_i)
                OFS_PW1: mag_q[0] <= host_wdata_i[MAG_W-1:0];
                OFS_PW2: mag_q[1] <= host_wdata_i[MAG_W-1:0];
                OFS_PW3: mag_q[2] <= host_wdata_i[MAG_W-1:0];
                OFS_PW4: mag_q[3] <= host_wdata_i[MAG_W-1:0];
                default: ;
            endcase
        end
    end

    // Reserved and unused offsets read as zero
    always_comb begin
        rd_mux = RD_ZERO;
        case (host_addr_i)
            OFS_CFG: rd_mux = cfg_q;
            OFS_CPE: rd_mux = cpe_q;
            OFS_PW1: rd_mux = {1'b0, mag_q[0]};
            OFS_PW2: rd_mux = {1'b0, mag_q[1]};
            OFS_PW3: rd_mux = {1'b0, mag_q[2]};
            OFS_PW4: rd_mux = {1'b0, mag_q[3]};
            default: rd_mux = RD_ZERO;
        endcase
    end

    // Read data stands until the next read replaces it
    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            rdata_q <= RD_ZERO;
            rvalid_q <= 1'b0;
        end else begin
            rvalid_q <= rd_hit;
            if (rd_hit) begin
                rdata_q <= rd_mux;
            end
        end
    end

    assign host_rdata_o = rdata_q;
    assign host_rvalid_o = rvalid_q;
    assign e1_mode_select_o = cfg_q[CFG_E1_BIT];
    assign line_frontend_disable_o = cfg_q[CFG_FE_DIS_BIT];
    assign los_threshold_select_o = cfg_q[CFG_LOS_BIT];
    assign custom_pulse_enable_o = cpe_q[CPE_CUSTOM_BIT];

    // Loss-of-signal threshold in dB
    logic [5:0] los_db_q;
    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            los_db_q <= LOS_LOW_DB;
        end else begin
            los_db_q <= cfg_q[CFG_LOS_BIT] ? LOS_HIGH_DB
                                           : LOS_LOW_DB;
        end
    end
    assign los_threshold_db_o = los_db_q;

    // Test source steering per flagged timeslot
    logic tx_mw_q, tx_prbs_q, rx_mw_q, rx_prbs_q;
    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            tx_mw_q <= 1'b0;
            tx_prbs_q <= 1'b0;
            rx_mw_q <= 1'b0;
            rx_prbs_q <= 1'b0;
        end else begin
            tx_mw_q <= tx_slot_test_flag_i && cfg_q[CFG_TEST_BIT];
            rx_mw_q <= rx_slot_test_flag_i && cfg_q[CFG_TEST_BIT];
            tx_prbs_q <= tx_slot_test_flag_i
                && !cfg_q[CFG_TEST_BIT];
            rx_prbs_q <= rx_slot_test_flag_i
                && !cfg_q[CFG_TEST_BIT];
        end
    end
    assign tx_milliwatt_sel_o = tx_mw_q;
    assign tx_prbs_gen_sel_o = tx_prbs_q;
    assign rx_milliwatt_sel_o = rx_mw_q;
    assign rx_prbs_chk_sel_o = rx_prbs_q;

    // Receive side; front-end enabled keeps the capture idle
    logic ext_clk_q, ext_rise, rx_a_q, rx_b_q, rx_stb_q;
    assign ext_rise = ext_rx_line_clock_i && !ext_clk_q;
    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            ext_clk_q <= 1'b0;
            rx_a_q <= 1'b0;
            rx_b_q <= 1'b0;
            rx_stb_q <= 1'b0;
        end else begin
            ext_clk_q <= ext_rx_line_clock_i;
            rx_stb_q <= ext_rise && cfg_q[CFG_FE_DIS_BIT];
            if (ext_rise && cfg_q[CFG_FE_DIS_BIT]) begin
                rx_a_q <= rx_line_in_a_i;
                rx_b_q <= rx_line_in_b_i;
            end
        end
    end
    assign rx_data_a_o = rx_a_q;
    assign rx_data_b_o = rx_b_q;
    assign rx_data_strobe_o = rx_stb_q;

    // Fractional divider: average 2.048 MHz, edges jitter by one cycle
    logic [ACC_W-1:0] acc_q;
    logic [ACC_W:0] acc_sum;
    logic clk_out_q;
    logic out_rise;
    assign acc_sum = {1'b0, acc_q} + {1'b0, TOGGLE_INC};
    assign out_rise = acc_sum[ACC_W] && !clk_out_q;
    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            acc_q <= '0;
            clk_out_q <= 1'b0;
        end else begin
            acc_q <= acc_sum[ACC_W-1:0];
            if (acc_sum[ACC_W]) begin
                clk_out_q <= !clk_out_q;
            end
        end
    end
    assign sys_clock_out_o = clk_out_q;

    // Transmit data leaves with the output clock rising edge
    logic tx_a_q;
    logic tx_b_q;
    logic tx_take_q;
    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            tx_a_q <= 1'b0;
            tx_b_q <= 1'b0;
            tx_take_q <= 1'b0;
        end else begin
            tx_take_q <= out_rise && cfg_q[CFG_FE_DIS_BIT];
            if (!cfg_q[CFG_FE_DIS_BIT]) begin
                tx_a_q <= 1'b0;
                tx_b_q <= 1'b0;
            end else if (out_rise) begin
                tx_a_q <= tx_data_a_i;
                tx_b_q <= tx_data_b_i;
            end
        end
    end
    assign tx_line_out_a_o = tx_a_q;
    assign tx_line_out_b_o = tx_b_q;
    assign tx_data_taken_o = tx_take_q;

    // Driver coefficient per mark phase; zero between marks
    logic [MAG_W-1:0] coeff_q;
    logic [MAG_W-1:0] cust_sel;
    assign cust_sel = mag_q[mark_phase_i];
    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            coeff_q <= '0;
        end else if (!mark_active_i) begin
            coeff_q <= '0;
        end else if (cpe_q[CPE_CUSTOM_BIT]) begin
            coeff_q <= cust_sel;
        end else begin
            coeff_q <= rom_coeff_i;
        end
    end
    assign driver_coeff_o = coeff_q;

    a_e1_mode_wr: assert property (@(posedge clk_i)
        disable iff (!reset_n_i)
        (wr_hit && host_addr_i == OFS_CFG) |=>
        e1_mode_select_o == $past(host_wdata_i[CFG_E1_BIT]))
        else $error("e1 mode bit not taken from write");
    a_fe_disable_wr: assert property (@(posedge clk_i)
        disable iff (!reset_n_i)
        (wr_hit && host_addr_i == OFS_CFG) |=>
        line_frontend_disable_o == $past(host_wdata_i[CFG_FE_DIS_BIT]))
        else $error("front-end disable bit not taken");
    a_rx_sample_edge: assert property (@(posedge clk_i)
        disable iff (!reset_n_i)
        (ext_rise && line_frontend_disable_o) |=>
        (rx_data_a_o == $past(rx_line_in_a_i)) &&
        (rx_data_b_o == $past(rx_line_in_b_i)) && rx_data_strobe_o)
        else $error("rx line not sampled on clock rise");
    a_tx_launch_edge: assert property (@(posedge clk_i)
        disable iff (!reset_n_i)
        ($changed(tx_line_out_a_o) && line_frontend_disable_o &&
        $past(line_frontend_disable_o)) |-> $rose(sys_clock_out_o))
        else $error("tx line changed away from clock rise");
    a_los_thresh_db: assert property (@(posedge clk_i)
        disable iff (!reset_n_i)
        ##1 los_threshold_db_o ==
        ($past(cfg_q[CFG_LOS_BIT]) ? 6'd20 : 6'd40))
        else $error("loss threshold does not follow select");
    a_mw_select: assert property (@(posedge clk_i)
        disable iff (!reset_n_i)
        (tx_slot_test_flag_i && cfg_q[CFG_TEST_BIT]) |=>
        tx_milliwatt_sel_o && !tx_prbs_gen_sel_o)
        else $error("milliwatt not chosen for flagged slot");
    a_prbs_select: assert property (@(posedge clk_i)
        disable iff (!reset_n_i)
        (rx_slot_test_flag_i && !cfg_q[CFG_TEST_BIT]) |=>
        rx_prbs_chk_sel_o && !rx_milliwatt_sel_o)
        else $error("prbs checker not chosen for flagged slot");
    a_rom_shape: assert property (@(posedge clk_i)
        disable iff (!reset_n_i)
        (mark_active_i && !custom_pulse_enable_o) |=>
        driver_coeff_o == $past(rom_coeff_i))
        else $error("rom template not used");
    a_custom_shape: assert property (@(posedge clk_i)
        disable iff (!reset_n_i)
        (mark_active_i && custom_pulse_enable_o) |=>
        driver_coeff_o == $past(cust_sel))
        else $error("custom word not used for phase");
    a_word1_phase: assert property (@(posedge clk_i)
        disable iff (!reset_n_i)
        (mark_active_i && custom_pulse_enable_o && mark_phase_i == 2'd0)
        |=> driver_coeff_o == $past(mag_q[0]))
        else $error("first phase not from word one");
    a_word2_phase: assert property (@(posedge clk_i)
        disable iff (!reset_n_i)
        (mark_active_i && custom_pulse_enable_o && mark_phase_i == 2'd1)
        |=> driver_coeff_o == $past(mag_q[1]))
        else $error("second phase not from word two");
    a_word4_phase: assert property (@(posedge clk_i)
        disable iff (!reset_n_i)
        (mark_active_i && custom_pulse_enable_o && mark_phase_i == 2'd3)
        |=> driver_coeff_o == $past(mag_q[3]))
        else $error("fourth phase not from word four");
    a_idle_coeff: assert property (@(posedge clk_i)
        disable iff (!reset_n_i)
        !mark_active_i |=> driver_coeff_o == 7'h00)
        else $error("coefficient driven outside a mark");

endmodule
`default_nettype wire

/* rtl/e1c_regs_unused_placeholder_none.sv */
// Intentionally empty design unit list
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

/* verif/tb.sv */
// Self-checking bench for the second control page register group
`timescale 1ns/1ps
`default_nettype none
module tb;
    import e1c_pkg::*;
    localparam int DLY = 10;
    typedef struct {
        logic [4:0] a;
        logic [7:0] w;
        logic [7:0] r;
    } e1c_tb_row_t;
    logic clk_i = 1'b0;
    logic reset_n_i = 1'b0;
    logic host_cs_i = 1'b0, host_wr_i = 1'b0, host_rd_i = 1'b0;
    logic [2:0] host_page_i = 3'h0;
    logic [4:0] host_addr_i = 5'h00;
    logic [7:0] host_wdata_i = 8'h00, host_rdata_o;
    logic host_rvalid_o, e1_mode_select_o, line_frontend_disable_o;
    logic los_threshold_select_o, custom_pulse_enable_o;
    logic [5:0] los_threshold_db_o;
    logic tx_slot_test_flag_i = 1'b0, rx_slot_test_flag_i = 1'b0;
    logic tx_milliwatt_sel_o, tx_prbs_gen_sel_o;
    logic rx_milliwatt_sel_o, rx_prbs_chk_sel_o;
    logic ext_rx_line_clock_i = 1'b0;
    logic rx_line_in_a_i = 1'b0, rx_line_in_b_i = 1'b0;
    logic rx_data_a_o, rx_data_b_o, rx_data_strobe_o;
    logic tx_data_a_i = 1'b0, tx_data_b_i = 1'b0;
    logic tx_line_out_a_o, tx_line_out_b_o, tx_data_taken_o;
    logic sys_clock_out_o, mark_active_i = 1'b0;
    logic [1:0] mark_phase_i = 2'h0;
    logic [MAG_W-1:0] rom_coeff_i = 7'h00, driver_coeff_o;
    int fails = 0;
    int total_checks = 0;
    // Words before custom enable; reserved slots read zero
    e1c_tb_row_t rows [8] = '{'{5'h10, 8'h98, 8'h98},
        '{5'h1c, 8'h11, 8'h11}, '{5'h1d, 8'h22, 8'h22},
        '{5'h1e, 8'h33, 8'h33}, '{5'h1f, 8'h44, 8'h44},
        '{5'h11, 8'h88, 8'h88}, '{5'h12, 8'hff, 8'h00},
        '{5'h1b, 8'h5a, 8'h00}};
    logic [6:0] words [4] = '{7'h11, 7'h22, 7'h33, 7'h44};
    int k;

    e1c_regs i_dut (.clk_i, .reset_n_i, .host_cs_i, .host_wr_i, .host_rd_i,
        .host_page_i, .host_addr_i, .host_wdata_i, .host_rdata_o,
        .host_rvalid_o, .e1_mode_select_o, .line_frontend_disable_o,
        .los_threshold_select_o, .los_threshold_db_o, .tx_slot_test_flag_i,
        .rx_slot_test_flag_i, .tx_milliwatt_sel_o, .tx_prbs_gen_sel_o,
        .rx_milliwatt_sel_o, .rx_prbs_chk_sel_o, .ext_rx_line_clock_i,
        .rx_line_in_a_i, .rx_line_in_b_i, .rx_data_a_o, .rx_data_b_o,
        .rx_data_strobe_o, .tx_data_a_i, .tx_data_b_i, .tx_line_out_a_o,
        .tx_line_out_b_o, .tx_data_taken_o, .sys_clock_out_o, .mark_active_i,
        .mark_phase_i, .rom_coeff_i, .custom_pulse_enable_o, .driver_coeff_o);

    always #50 clk_i = ~clk_i;

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        total_checks++;
        if (seen !== exp) begin
            fails++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic results();
        if (fails == 0 && total_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // Every task is entered and left just after a rising edge
    task automatic cyc(input int n);
        repeat (n) @(posedge clk_i);
        #DLY;
    endtask

    task automatic wr(input logic [2:0] pg, input logic [4:0] a,
                      input logic [7:0] d);
        host_cs_i = 1'b1;
        host_wr_i = 1'b1;
        host_page_i = pg;
        host_addr_i = a;
        host_wdata_i = d;
        cyc(1);
        host_cs_i = 1'b0;
        host_wr_i = 1'b0;
        // Idle edge so a following request never re-raises at once
        cyc(1);
    endtask

    task automatic rd(input logic [2:0] pg, input logic [4:0] a,
                      input logic [7:0] exp, input logic vld);
        host_cs_i = 1'b1;
        host_rd_i = 1'b1;
        host_page_i = pg;
        host_addr_i = a;
        cyc(1);
        host_cs_i = 1'b0;
        host_rd_i = 1'b0;
        check(host_rvalid_o, vld);
        if (vld) begin
            check(host_rdata_o, exp);
        end
        cyc(1);
    endtask

    initial begin
        cyc(16);
        reset_n_i = 1'b1;
        check(e1_mode_select_o, 1'b1);
        check(los_threshold_db_o, LOS_LOW_DB);
        rd(PAGE_CTRL2, OFS_CFG, 8'h80, 1'b1);
        rd(PAGE_CTRL2, OFS_CPE, 8'h80, 1'b1);
        rd(PAGE_CTRL2, OFS_PW1, 8'h00, 1'b1);
        foreach (rows[i]) begin
            wr(PAGE_CTRL2, rows[i].a, rows[i].w);
            rd(PAGE_CTRL2, rows[i].a, rows[i].r, 1'b1);
        end
        check(e1_mode_select_o, 1'b1);
        check(line_frontend_disable_o, 1'b1);
        check(los_threshold_select_o, 1'b1);
        check(los_threshold_db_o, LOS_HIGH_DB);
        check(custom_pulse_enable_o, 1'b1);
        // Other pages neither store nor answer
        wr(3'h1, OFS_CFG, 8'h00);
        rd(PAGE_CTRL2, OFS_CFG, 8'h98, 1'b1);
        rd(3'h1, OFS_CFG, 8'h00, 1'b0);
        // Custom phases, then ROM path, then idle line
        rom_coeff_i = 7'h6b;
        mark_active_i = 1'b1;
        for (int p = 0; p < 4; p++) begin
            mark_phase_i = p[1:0];
            cyc(1);
            check(driver_coeff_o, words[p]);
        end
        wr(PAGE_CTRL2, OFS_CPE, 8'h80);
        cyc(1);
        check(custom_pulse_enable_o, 1'b0);
        check(driver_coeff_o, 7'h6b);
        mark_active_i = 1'b0;
        cyc(1);
        check(driver_coeff_o, 7'h00);
        // Digital receive capture, two patterns
        for (int n = 0; n < 2; n++) begin
            rx_line_in_a_i = (n == 0);
            rx_line_in_b_i = (n != 0);
            ext_rx_line_clock_i = 1'b1;
            k = 0;
            while (rx_data_strobe_o !== 1'b1 && k < 6) begin
                cyc(1);
                k++;
            end
            check(rx_data_strobe_o, 1'b1);
            check({rx_data_a_o, rx_data_b_o}, {n == 0, n != 0});
            ext_rx_line_clock_i = 1'b0;
            cyc(1);
            check(rx_data_strobe_o, 1'b0);
            cyc(1);
        end
        // Digital transmit launch on each output clock rise
        for (int n = 0; n < 4; n++) begin
            k = 0;
            cyc(1);
            while (tx_data_taken_o !== 1'b1 && k < 8) begin
                cyc(1);
                k++;
            end
            check(sys_clock_out_o, 1'b1);
            check({tx_line_out_a_o, tx_line_out_b_o},
                  {tx_data_a_i, tx_data_b_i});
            if (n > 0) begin
                check(k >= 3 && k <= 4, 1'b1);
            end
            tx_data_a_i = n[0];
            tx_data_b_i = ~n[0];
        end
        // Front-end enabled: no digital line traffic
        wr(PAGE_CTRL2, OFS_CFG, 8'h02);
        tx_data_a_i = 1'b1;
        tx_data_b_i = 1'b1;
        ext_rx_line_clock_i = 1'b1;
        tx_slot_test_flag_i = 1'b1;
        rx_slot_test_flag_i = 1'b1;
        for (int c = 0; c < 12; c++) begin
            cyc(1);
            ext_rx_line_clock_i = c[0];
            check(rx_data_strobe_o, 1'b0);
            check({tx_line_out_a_o, tx_line_out_b_o, tx_data_taken_o},
                  3'b000);
        end
        check(e1_mode_select_o, 1'b0);
        check(los_threshold_db_o, LOS_LOW_DB);
        check({tx_milliwatt_sel_o, rx_milliwatt_sel_o}, 2'b11);
        check({tx_prbs_gen_sel_o, rx_prbs_chk_sel_o}, 2'b00);
        wr(PAGE_CTRL2, OFS_CFG, 8'h80);
        cyc(2);
        check({tx_milliwatt_sel_o, rx_milliwatt_sel_o}, 2'b00);
        check({tx_prbs_gen_sel_o, rx_prbs_chk_sel_o}, 2'b11);
        rx_slot_test_flag_i = 1'b0;
        cyc(2);
        check({tx_prbs_gen_sel_o, rx_prbs_chk_sel_o}, 2'b10);
        // Reset again in mid-run
        wr(PAGE_CTRL2, OFS_CPE, 8'h88);
        reset_n_i = 1'b0;
        cyc(2);
        reset_n_i = 1'b1;
        check(custom_pulse_enable_o, 1'b0);
        rd(PAGE_CTRL2, OFS_CPE, 8'h80, 1'b1);
        rd(PAGE_CTRL2, OFS_PW2, 8'h00, 1'b1);
        results();
    end

    // Whole run is about 120 cycles, well inside this 5000-cycle limit
    initial begin
        #(100 * 5000);
        fails++;
        results();
    end
endmodule
`default_nettype wire
